// [sfp_pkg.sv]
// constants, field layout and types of the sensor fifo frame packer
package sfp_pkg;
  // ****************************************************************
  // storage geometry
  // ****************************************************************
  localparam int SFP_DEPTH = 1024;
  localparam int SFP_PTR_W = 10;
  localparam int SFP_FILL_W = 11;
  localparam logic [SFP_FILL_W-1:0] SFP_DEPTH_FILL = 11'h400;

  // ****************************************************************
  // register offsets (byte addresses) and reset values
  // ****************************************************************
  localparam logic [7:0] SFP_OFS_CONFIG = 8'h00;
  localparam logic [7:0] SFP_OFS_STATUS = 8'h04;
  localparam logic [7:0] SFP_OFS_DATA = 8'h08;
  localparam int SFP_CFG_W = 15;
  localparam logic [SFP_CFG_W-1:0] SFP_CONFIG_RESET = 15'h0005;

  // config fields
  localparam int SFP_CFG_HDR_EN = 0;
  localparam int SFP_CFG_STOP_FULL = 1;
  localparam int SFP_CFG_ACC_EN = 2;
  localparam int SFP_CFG_AUX_EN = 3;
  localparam int SFP_CFG_BURST_LO = 4;
  localparam int SFP_CFG_UNFILT = 6;
  localparam int SFP_CFG_TAG_ONE = 7;
  localparam int SFP_CFG_TAG_TWO = 8;
  localparam int SFP_CFG_DOWNS_LO = 12;

  // status fields
  localparam int SFP_ST_FILL_LO = 0;
  localparam int SFP_ST_ERR = 16;
  localparam int SFP_ST_SKIP_LO = 24;

  // ****************************************************************
  // frame encoding
  // ****************************************************************
  localparam logic [1:0] SFP_KIND_REGULAR = 2'b10;
  localparam logic [1:0] SFP_KIND_CONTROL = 2'b01;
  localparam logic [3:0] SFP_OP_SKIP = 4'h0;
  localparam int SFP_PARM_AUX = 2;
  localparam int SFP_PARM_ACC = 0;
  localparam int SFP_HDR_AUX_BIT = 4;
  localparam int SFP_HDR_ACC_BIT = 2;
  localparam logic [7:0] SFP_SKIP_HEADER = {SFP_KIND_CONTROL, SFP_OP_SKIP, 2'b00};
  localparam logic [7:0] SFP_HDR_INVALID = 8'h80;
  localparam logic [7:0] SFP_OVR_LSB = 8'h00;
  localparam logic [7:0] SFP_OVR_MSB = 8'h80;
  localparam logic [7:0] SFP_SKIP_MAX = 8'hFF;
  localparam logic [3:0] SFP_HDR_BYTES = 4'h1;
  localparam logic [3:0] SFP_AUX_MAX = 4'h8;
  localparam logic [3:0] SFP_ACC_BYTES = 4'h6;
  localparam int SFP_STAGE = 15;
  localparam logic [3:0] SFP_MAX_HDR_FRAME = 4'hF;
  localparam logic [3:0] SFP_MAX_RAW_FRAME = 4'hE;

  // ****************************************************************
  // rates
  // ****************************************************************
  localparam int SFP_CLK_HZ = 40000000;
  localparam int SFP_UNFILT_HZ = 1600;
  localparam int SFP_UNFILT_DIV = SFP_CLK_HZ / SFP_UNFILT_HZ;
  localparam int SFP_DEC_W = 7;

  // auxiliary burst code to byte count
  function automatic logic [3:0] sfp_aux_len(input logic [1:0] burst);
    case (burst)
      2'b00: sfp_aux_len = 4'h1;
      2'b01: sfp_aux_len = 4'h2;
      2'b10: sfp_aux_len = 4'h6;
      default: sfp_aux_len = 4'h8;
    endcase
  endfunction

  typedef enum logic [3:0] {
    SFP_W_IDLE = 4'b0001,
    SFP_W_CHECK = 4'b0010,
    SFP_W_DROP = 4'b0100,
    SFP_W_WRITE = 4'b1000
  } sfp_wr_state_type;

  typedef enum logic [3:0] {
    SFP_RK_SKIP_HDR = 4'b0001,
    SFP_RK_SKIP_CNT = 4'b0010,
    SFP_RK_OVER = 4'b0100,
    SFP_RK_DATA = 4'b1000
  } sfp_rd_kind_type;
endpackage

// [sfp_rate_gen.sv]
// fifo input tick: unfiltered 1600 Hz divider or odr tick, then 2^k decimation
`timescale 1ns/100ps
module sfp_rate_gen
  import sfp_pkg::*;
#(
  parameter int DIV = SFP_UNFILT_DIV
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic unfilt_sel,
  input wire logic acc_tick,
  input wire logic [2:0] downs_k,
  output logic fifo_tick
);
  logic [$clog2(DIV)-1:0] div_cnt;
  logic [SFP_DEC_W-1:0] dec_cnt;
  logic [SFP_DEC_W-1:0] dec_mask;
  logic div_pulse;
  logic src_tick;

  // 1600 Hz enable from the bus clock
  assign div_pulse = (div_cnt == ($clog2(DIV))'(DIV - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= '0;
    end else if (div_pulse) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  // keep one source tick out of every 2^k
  assign src_tick = unfilt_sel ? div_pulse : acc_tick;
  assign dec_mask = SFP_DEC_W'((8'h01 << downs_k) - 8'h01);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dec_cnt <= '0;
      fifo_tick <= 1'b0;
    end else begin
      fifo_tick <= src_tick && ((dec_cnt & dec_mask) == '0);
      if (src_tick) begin
        dec_cnt <= dec_cnt + 1'b1;
      end
    end
  end
endmodule

// [sfp_frame_packer.sv]
// sensor fifo frame packer: framing, overflow policy and apb read-out
`timescale 1ns/100ps
// Operation
// - header holds kind, parameter and tag fields
// - kind 10 regular, 01 control frame
// - regular parameter never zero; 0x80 invalid
// - parameter bit2 aux, bit0 accelerometer
// - tag field carries interrupt pin levels
// - payload aux bytes then X, Y, Z
// - only frames with sensor data stored
// - header mode aux bytes equal burst
// - headerless aux slots padded to eight
// - headerless frames regular and equal length
// - headerless layout change flushes the fifo
// - frame rate follows fastest enabled sensor
// - unfiltered accelerometer feeds at 1600 Hz
// - decimation by two to the k
// - overwrite mode deletes oldest, skip frame
// - stop mode discards newest, skip frame
// - no tail drop during read; error flag
// - storage depth 1024 bytes
// - skip frame counts losses, saturates, no storage
// - overread returns 0x8000 or 0x80
// - partly read frame presented again whole
module sfp_frame_packer
  import sfp_pkg::*;
#(
  parameter int DEPTH = SFP_DEPTH,
  parameter int UNFILT_DIV = SFP_UNFILT_DIV
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic acc_tick,
  input wire logic aux_tick,
  input wire logic [15:0] acc_x,
  input wire logic [15:0] acc_y,
  input wire logic [15:0] acc_z,
  input wire logic [63:0] aux_data,
  input wire logic interrupt_pin_one,
  input wire logic interrupt_pin_two
);
  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [SFP_CFG_W-1:0] config_reg;
  logic fifo_err;
  logic [7:0] skip_cnt;
  logic [7:0] mem [DEPTH];
  logic [SFP_PTR_W-1:0] wr_ptr;
  logic [SFP_PTR_W-1:0] rd_ptr;
  logic [SFP_FILL_W-1:0] fill;
  logic [3:0] rd_offset;
  logic skip_phase;
  logic ovr_msb;
  sfp_rd_kind_type rd_kind;
  sfp_wr_state_type wr_state;
  logic [7:0] stg [SFP_STAGE];
  logic [7:0] next_stg [SFP_STAGE];
  logic [3:0] stg_len;
  logic [3:0] next_len;
  logic [3:0] wr_idx;
  logic int_one_meta, int_one_sync, int_two_meta, int_two_sync;
  logic fifo_tick;
  logic hdr_en, stop_full, acc_en, aux_en;
  logic [3:0] aux_len;
  logic acc_ev, aux_ev, frame_ev, acc_in, aux_in;
  logic [7:0] header;
  logic apb_setup, apb_done, data_rd, flush, reading;
  logic [SFP_CFG_W-1:0] new_cfg;
  logic [3:0] cur_len, max_frame, raw_len;
  logic [SFP_FILL_W-1:0] free;
  logic commit, drop_do, pop, skip_inc, skip_clr, err_set, err_clr;
  logic [7:0] rd_byte;
  sfp_rd_kind_type next_kind;

  assign hdr_en = config_reg[SFP_CFG_HDR_EN];
  assign stop_full = config_reg[SFP_CFG_STOP_FULL];
  assign acc_en = config_reg[SFP_CFG_ACC_EN];
  assign aux_en = config_reg[SFP_CFG_AUX_EN];
  assign aux_len = sfp_aux_len(config_reg[SFP_CFG_BURST_LO +: 2]);

  // ****************************************************************
  // pin synchronisers and rate generation
  // ****************************************************************
  // tag pins are asynchronous, two flops before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_one_meta <= 1'b0;
      int_one_sync <= 1'b0;
      int_two_meta <= 1'b0;
      int_two_sync <= 1'b0;
    end else begin
      int_one_meta <= interrupt_pin_one;
      int_one_sync <= int_one_meta;
      int_two_meta <= interrupt_pin_two;
      int_two_sync <= int_two_meta;
    end
  end

  sfp_rate_gen #(.DIV(UNFILT_DIV)) u_rate (
    .pclk(pclk),
    .presetn(presetn),
    .unfilt_sel(config_reg[SFP_CFG_UNFILT]),
    .acc_tick(acc_tick),
    .downs_k(config_reg[SFP_CFG_DOWNS_LO +: 3]),
    .fifo_tick(fifo_tick)
  );

  // ****************************************************************
  // apb decode
  // ****************************************************************
  assign apb_setup = psel && !penable;
  assign apb_done = psel && penable && pready;
  assign data_rd = apb_done && !pwrite && (paddr == SFP_OFS_DATA);
  assign new_cfg = pwdata[SFP_CFG_W-1:0];
  // headerless layout, header toggle or aux size change restarts capture
  assign flush = apb_done && pwrite && (paddr == SFP_OFS_CONFIG) &&
                 ((new_cfg[SFP_CFG_HDR_EN] != hdr_en) ||
                  (new_cfg[SFP_CFG_BURST_LO +: 2] != config_reg[SFP_CFG_BURST_LO +: 2]) ||
                  (!hdr_en && (new_cfg[SFP_CFG_ACC_EN +: 2] !=
                               config_reg[SFP_CFG_ACC_EN +: 2])));
  // a read burst in progress blocks any drop at the tail
  assign reading = (rd_offset != 4'h0) || skip_phase ||
                   (psel && !pwrite && (paddr == SFP_OFS_DATA));
  assign err_clr = apb_done && pwrite && (paddr == SFP_OFS_STATUS) && pwdata[SFP_ST_ERR];

  // configuration register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_reg <= SFP_CONFIG_RESET;
    end else if (apb_done && pwrite && (paddr == SFP_OFS_CONFIG)) begin
      config_reg <= new_cfg;
    end
  end

  // ****************************************************************
  // frame assembly
  // ****************************************************************
  assign acc_ev = acc_en && fifo_tick;
  assign aux_ev = aux_en && aux_tick;
  assign frame_ev = acc_ev || aux_ev;
  // headerless frames always carry every enabled sensor
  assign acc_in = hdr_en ? acc_ev : acc_en;
  assign aux_in = hdr_en ? aux_ev : aux_en;
  assign header = {SFP_KIND_REGULAR, 1'b0, aux_in, 1'b0, acc_in,
                   int_two_sync && config_reg[SFP_CFG_TAG_TWO],
                   int_one_sync && config_reg[SFP_CFG_TAG_ONE]};

  always_comb begin
    logic [3:0] n;
    logic [3:0] na;
    n = 4'h0;
    na = hdr_en ? aux_len : SFP_AUX_MAX;
    for (int i = 0; i < SFP_STAGE; i++) begin
      next_stg[i] = 8'h00;
    end
    if (hdr_en) begin
      next_stg[0] = header;
      n = SFP_HDR_BYTES;
    end
    // aux bytes first, beyond the burst the headerless slots hold the upper aux_data bytes of the same sample
    if (aux_in) begin
      for (int i = 0; i < 8; i++) begin
        if (4'(i) < na) begin
          next_stg[4'(n + 4'(i))] = aux_data[i*8 +: 8];
        end
      end
      n = n + na;
    end
    if (acc_in) begin
      next_stg[n] = acc_x[7:0];
      next_stg[4'(n + 4'h1)] = acc_x[15:8];
      next_stg[4'(n + 4'h2)] = acc_y[7:0];
      next_stg[4'(n + 4'h3)] = acc_y[15:8];
      next_stg[4'(n + 4'h4)] = acc_z[7:0];
      next_stg[4'(n + 4'h5)] = acc_z[15:8];
      n = n + SFP_ACC_BYTES;
    end
    next_len = n;
  end

  // frame length of the oldest stored frame
  assign raw_len = (aux_en ? SFP_AUX_MAX : 4'h0) + (acc_en ? SFP_ACC_BYTES : 4'h0);
  assign cur_len = hdr_en ? (SFP_HDR_BYTES +
                    (mem[rd_ptr][SFP_HDR_AUX_BIT] ? aux_len : 4'h0) +
                    (mem[rd_ptr][SFP_HDR_ACC_BIT] ? SFP_ACC_BYTES : 4'h0)) : raw_len;
  assign max_frame = hdr_en ? SFP_MAX_HDR_FRAME : SFP_MAX_RAW_FRAME;
  assign free = SFP_FILL_W'(DEPTH) - fill;

  // ****************************************************************
  // write side state machine
  // ****************************************************************
  assign commit = (wr_state == SFP_W_WRITE) && (wr_idx == 4'(stg_len - 4'h1));
  assign drop_do = (wr_state == SFP_W_DROP) && !reading && (fill != '0);
  assign skip_inc = ((wr_state == SFP_W_CHECK) && (free < {7'h00, max_frame}) &&
                     (stop_full || reading)) || drop_do;
  assign err_set = (wr_state == SFP_W_CHECK) && (free < {7'h00, max_frame}) && reading;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_state <= SFP_W_IDLE;
      wr_idx <= 4'h0;
      stg_len <= 4'h0;
      wr_ptr <= '0;
      for (int i = 0; i < SFP_STAGE; i++) begin
        stg[i] <= 8'h00;
      end
    end else if (flush) begin
      wr_state <= SFP_W_IDLE;
      wr_ptr <= '0;
    end else begin
      case (wr_state)
        SFP_W_IDLE: begin
          // an empty frame never enters the fifo
          if (frame_ev && (next_len != 4'h0)) begin
            stg <= next_stg;
            stg_len <= next_len;
            wr_state <= SFP_W_CHECK;
          end
        end
        SFP_W_CHECK: begin
          wr_idx <= 4'h0;
          if (free >= {7'h00, max_frame}) begin
            wr_state <= SFP_W_WRITE;
          end else if (stop_full || reading) begin
            wr_state <= SFP_W_IDLE;
          end else begin
            wr_state <= SFP_W_DROP;
          end
        end
        SFP_W_DROP: begin
          wr_state <= SFP_W_CHECK;
        end
        SFP_W_WRITE: begin
          wr_idx <= wr_idx + 4'h1;
          if (commit) begin
            wr_ptr <= wr_ptr + SFP_PTR_W'(stg_len);
            wr_state <= SFP_W_IDLE;
          end
        end
        default: begin
          wr_state <= SFP_W_IDLE;
        end
      endcase
    end
  end

  // storage, header byte first then payload in index order
  always_ff @(posedge pclk) begin
    if (wr_state == SFP_W_WRITE) begin
      mem[SFP_PTR_W'(wr_ptr + SFP_PTR_W'(wr_idx))] <= stg[wr_idx];
    end
  end

  // skip counter lives outside storage; a new loss wins over the clear
  assign skip_clr = data_rd && (rd_kind == SFP_RK_SKIP_CNT);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      skip_cnt <= 8'h00;
    end else if (flush) begin
      skip_cnt <= 8'h00;
    end else if (skip_inc) begin
      skip_cnt <= skip_clr ? 8'h01 :
                  ((skip_cnt == SFP_SKIP_MAX) ? SFP_SKIP_MAX : skip_cnt + 8'h01);
    end else if (skip_clr) begin
      skip_cnt <= 8'h00;
    end
  end

  // overflow error flag, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_err <= 1'b0;
    end else if (err_set) begin
      fifo_err <= 1'b1;
    end else if (err_clr) begin
      fifo_err <= 1'b0;
    end
  end

  // ****************************************************************
  // read side
  // ****************************************************************
  assign pop = data_rd && (rd_kind == SFP_RK_DATA) &&
               (rd_offset == 4'(cur_len - 4'h1));

  // fill level and read pointer move by whole frames only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fill <= '0;
      rd_ptr <= '0;
    end else if (flush) begin
      fill <= '0;
      rd_ptr <= '0;
    end else begin
      fill <= fill + (commit ? SFP_FILL_W'(stg_len) : '0)
                   - ((pop || drop_do) ? SFP_FILL_W'(cur_len) : '0);
      if (pop || drop_do) begin
        rd_ptr <= rd_ptr + SFP_PTR_W'(cur_len);
      end
    end
  end

  // byte offset within the frame being read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_offset <= 4'h0;
      skip_phase <= 1'b0;
      ovr_msb <= 1'b0;
    end else if (flush || (apb_done && !data_rd)) begin
      // any other access ends the burst; a partial frame starts over
      rd_offset <= 4'h0;
      skip_phase <= 1'b0;
      ovr_msb <= 1'b0;
    end else if (data_rd) begin
      case (rd_kind)
        SFP_RK_SKIP_HDR: skip_phase <= 1'b1;
        SFP_RK_SKIP_CNT: skip_phase <= 1'b0;
        SFP_RK_OVER: ovr_msb <= !ovr_msb;
        default: rd_offset <= pop ? 4'h0 : rd_offset + 4'h1;
      endcase
    end
  end

  // what the data register shows, fixed at the setup cycle
  always_comb begin
    next_kind = SFP_RK_DATA;
    rd_byte = mem[SFP_PTR_W'(rd_ptr + SFP_PTR_W'(rd_offset))];
    if (skip_phase) begin
      next_kind = SFP_RK_SKIP_CNT;
      rd_byte = skip_cnt;
    end else if (hdr_en && (skip_cnt != 8'h00) && (rd_offset == 4'h0)) begin
      next_kind = SFP_RK_SKIP_HDR;
      rd_byte = SFP_SKIP_HEADER;
    end else if (fill == '0) begin
      next_kind = SFP_RK_OVER;
      rd_byte = hdr_en ? SFP_HDR_INVALID : (ovr_msb ? SFP_OVR_MSB : SFP_OVR_LSB);
    end
  end

  // ****************************************************************
  // apb answer, one wait-free access phase after setup
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      rd_kind <= SFP_RK_DATA;
    end else begin
      pready <= apb_setup;
      pslverr <= 1'b0;
      if (apb_setup) begin
        rd_kind <= next_kind;
        prdata <= 32'h00000000;
        if (paddr == SFP_OFS_CONFIG) begin
          prdata <= {17'h0, config_reg};
        end else if (paddr == SFP_OFS_STATUS) begin
          prdata <= {skip_cnt, 7'h00, fifo_err, 5'h00, fill};
        end else if (paddr == SFP_OFS_DATA) begin
          prdata <= {24'h000000, rd_byte};
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end
endmodule

// [sfp_frame_packer_sva.sv]
// assertion checker for the frame packer register port
`timescale 1ns/100ps
module sfp_frame_packer_sva
  import sfp_pkg::*;
#(
  parameter int DEPTH = SFP_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // ********
  // helpers
  // ********
  logic mapped;
  logic rd_ok;
  logic [14:0] shadow;
  assign mapped = paddr == SFP_OFS_CONFIG || paddr == SFP_OFS_STATUS || paddr == SFP_OFS_DATA;
  assign rd_ok = pready && !pwrite && !pslverr;
  // last accepted config, masked: bits 11:9 are unused and need not read back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shadow <= SFP_CONFIG_RESET;
    end else if (pready && pwrite && paddr == SFP_OFS_CONFIG) begin
      shadow <= pwdata[14:0] & 15'h71FF;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ********
  // properties
  // ********
  a_ready_after_setup: assert property (psel && !penable |=> pready && penable)
    else $error("no answer in the cycle after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside an access phase");
  a_unmapped_refused: assert property (pready && !mapped |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_mapped_no_err: assert property (pready && mapped |-> !pslverr)
    else $error("error on a mapped register");
  a_data_one_byte: assert property (rd_ok && paddr == SFP_OFS_DATA |-> prdata[31:8] == 24'h0)
    else $error("data read wider than one byte");
  a_fill_in_depth: assert property (rd_ok && paddr == SFP_OFS_STATUS |-> int'(prdata[10:0]) <= DEPTH)
    else $error("fill level above storage depth");
  a_config_readback: assert property (rd_ok && paddr == SFP_OFS_CONFIG |->
    (prdata[14:0] & 15'h71FF) == shadow)
    else $error("config reads back a different value");
  a_reset_quiet: assert property ($rose(presetn) |-> !pready && !pslverr)
    else $error("answer right after reset");
endmodule

bind sfp_frame_packer sfp_frame_packer_sva #(.DEPTH(DEPTH)) chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr));

// [sfp_apb_host.sv]
// apb host model that configures the packer and reads its frames
`timescale 1ns/100ps
module sfp_apb_host (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // a header of 0x80 is taken as no frame at all
  function automatic logic hdr_ok(input logic [7:0] b);
    return b != 8'h80;
  endfunction
  // one transfer; waits for ready with no cycle count assumed
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    // released lines show garbage, not the last value
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// [sfp_frame_packer_test.sv]
// self-checking testbench of the sensor fifo frame packer
`timescale 1ns/100ps
module sfp_frame_packer_test
  import sfp_pkg::*;
;
  localparam int DIV = 40;
  localparam int LIMIT = 40000;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, acc_tick, aux_tick, pin1, pin2, perr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, seed, q;
  logic [15:0] acc_x, acc_y, acc_z;
  logic [63:0] aux_data;
  logic [7:0] eb [16];
  int err_total, checks_done, cycles, nb;

  // ********
  // instances
  // ********
  sfp_frame_packer #(.DEPTH(SFP_DEPTH), .UNFILT_DIV(DIV)) uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .acc_tick(acc_tick),
    .aux_tick(aux_tick), .acc_x(acc_x), .acc_y(acc_y), .acc_z(acc_z), .aux_data(aux_data),
    .interrupt_pin_one(pin1), .interrupt_pin_two(pin2));
  sfp_apb_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // ********
  // expectation helpers
  // ********
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] cfg(input logic h, input logic st, input logic ac,
      input logic ax, input logic [1:0] b, input logic u, input logic [2:0] k);
    return {17'h0, k, 3'b000, 2'b11, u, b, ax, ac, st, h};
  endfunction
  function automatic int aux_len(input logic [1:0] b);
    return (b == 2'b00) ? 1 : (b == 2'b01) ? 2 : (b == 2'b10) ? 6 : 8;
  endfunction
  function automatic logic [7:0] hdr(input logic ax, input logic ac);
    return {2'b10, 1'b0, ax, 1'b0, ac, pin2, pin1};
  endfunction
  task automatic rnd();
    repeat (32) seed = lfsr(seed);
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a);
    host.xfer(1'b0, a, 32'h0, q, perr);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    host.xfer(1'b1, a, d, x, perr);
  endtask
  task automatic fill_is(input int n);
    rd(SFP_OFS_STATUS);
    chk({21'h0, q[10:0]}, n);
  endtask
  // header toggled twice so every run starts from an empty store
  task automatic fresh(input logic [31:0] c);
    rnd();
    pin1 <= seed[0];
    pin2 <= seed[1];
    wr(SFP_OFS_CONFIG, c ^ 32'h1);
    wr(SFP_OFS_CONFIG, c);
  endtask
  // one sample with fresh random data, then room for the frame to land
  task automatic tick(input logic a, input logic x);
    @(posedge pclk);
    rnd();
    acc_x <= seed[15:0];
    acc_y <= seed[31:16];
    rnd();
    acc_z <= seed[15:0];
    rnd();
    aux_data <= {seed, ~seed ^ 32'h5A3C_96E1};
    acc_tick <= a;
    aux_tick <= x;
    @(posedge pclk);
    acc_tick <= 1'b0;
    aux_tick <= 1'b0;
    repeat (18) @(posedge pclk);
  endtask
  task automatic build(input logic h, input logic ax, input int alen, input logic ac);
    nb = h ? 1 : 0;
    if (h) eb[0] = hdr(ax, ac);
    for (int i = 0; i < alen; i++) eb[nb+i] = aux_data[8*i+:8];
    nb = nb + alen;
    if (ac) {eb[nb], eb[nb+1], eb[nb+2], eb[nb+3], eb[nb+4], eb[nb+5]} =
      {acc_x[7:0], acc_x[15:8], acc_y[7:0], acc_y[15:8], acc_z[7:0], acc_z[15:8]};
    if (ac) nb = nb + 6;
  endtask
  task automatic take(input int n);
    for (int i = 0; i < n; i++) begin
      rd(SFP_OFS_DATA);
      chk(q, {24'h0, eb[i]});
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ********
  // clock, inputs and hang guard
  // ********
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0;
    {acc_tick, aux_tick, pin1, pin2} = 4'h0;
    {acc_x, acc_y, acc_z, aux_data} = 112'h0;
    {err_total, checks_done, cycles} = '0;
    seed = 32'h2f49a620;
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      err_total++;
      $display("[ERR] %0t run too long", $time);
      print_verdict();
    end
  end

  // ********
  // scenarios
  // ********
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(SFP_OFS_CONFIG);
    chk(q, {17'h0, SFP_CONFIG_RESET});
    fill_is(0);
    rd(8'h0C);
    chk(q, 32'h0);
    chk({31'h0, perr}, 32'h1);
    $display("test reset done");
    // accelerometer frame, partial read, reread, overread
    fresh(cfg(1, 0, 1, 0, 0, 0, 0));
    tick(1, 0);
    build(1, 0, 0, 1);
    fill_is(7);
    take(3);
    rd(SFP_OFS_STATUS);
    take(7);
    rd(SFP_OFS_DATA);
    chk({31'h0, host.hdr_ok(q[7:0])}, 0);
    $display("test acc_frame done");
    // every auxiliary burst length in header mode
    for (int b = 0; b < 4; b++) begin
      fresh(cfg(1, 0, 0, 1, b[1:0], 0, 0));
      tick(0, 1);
      build(1, 1, aux_len(b[1:0]), 0);
      fill_is(nb);
      take(nb);
    end
    $display("test aux_burst done");
    // headerless single sensor: padding, overread, flush
    fresh(cfg(0, 0, 0, 1, 2'b01, 0, 0));
    tick(0, 1);
    build(0, 1, 2, 0);
    fill_is(8);
    take(2);
    repeat (6) rd(SFP_OFS_DATA);
    rd(SFP_OFS_DATA);
    chk(q, 32'h00);
    rd(SFP_OFS_DATA);
    chk(q, 32'h80);
    tick(0, 1);
    wr(SFP_OFS_CONFIG, cfg(0, 0, 0, 1, 2'b10, 0, 0));
    fill_is(0);
    fresh(cfg(1, 0, 0, 0, 0, 0, 0));
    tick(1, 1);
    fill_is(0);
    $display("test headerless done");
    // stop on full while a read is in progress
    fresh(cfg(1, 1, 1, 0, 0, 0, 0));
    tick(1, 0);
    rd(SFP_OFS_DATA);
    repeat (149) tick(1, 0);
    rd(SFP_OFS_STATUS);
    chk({q[31:24], q[16], 5'h0, q[10:0]}, {8'h05, 1'b1, 5'h0, 11'd1015});
    wr(SFP_OFS_STATUS, 32'h0001_0000);
    rd(SFP_OFS_STATUS);
    chk({31'h0, q[16]}, 0);
    rd(SFP_OFS_DATA);
    chk(q, {24'h0, SFP_SKIP_HEADER});
    rd(SFP_OFS_DATA);
    chk(q, 32'h05);
    $display("test stop_full done");
    // overwrite mode keeps the newest frames
    fresh(cfg(1, 0, 1, 0, 0, 0, 0));
    repeat (150) tick(1, 0);
    rd(SFP_OFS_DATA);
    chk(q, {24'h0, SFP_SKIP_HEADER});
    rd(SFP_OFS_DATA);
    chk({31'h0, q[7:0] != 8'h0}, 1);
    rd(SFP_OFS_DATA);
    chk(q, {24'h0, hdr(0, 1)});
    $display("test overwrite done");
    // unfiltered source decimated by two to the k, eight periods each
    for (int k = 0; k < 4; k++) begin
      fresh(cfg(1, 0, 1, 0, 0, 1, k[2:0]));
      repeat (DIV * (1 << k) * 8) @(posedge pclk);
      wr(SFP_OFS_CONFIG, cfg(1, 0, 0, 0, 0, 1, k[2:0]));
      rd(SFP_OFS_STATUS);
      chk({31'h0, q[10:0] >= 11'd49 && q[10:0] <= 11'd63}, 1);
    end
    $display("test decimation done");
    print_verdict();
  end
endmodule
